// file: verilog/dvt_pkg.sv
package dvt_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // Power-up select delay; the figure is a plain default
  localparam int unsigned PWRUP_DELAY_NS  = 1000;
  // Least time, so round up to whole cycles
  localparam int unsigned PWRUP_DELAY_CYC =
    (PWRUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ARRAY  = 8'h08;
  localparam logic [7:0] OFS_SUPPLY = 8'h60;
  localparam logic [7:0] OFS_CAPS   = 8'h64;
  localparam logic [7:0] OFS_LOCK   = 8'h68;
  localparam logic [7:0] OFS_SPARE  = 8'h6c;

  // ****************************************************************
  // Table words, lowest byte address in bits 7:0
  // ****************************************************************
  localparam logic [15:0] SUPPLY_MAX    = 16'h3600;
  localparam logic [15:0] SUPPLY_MIN    = 16'h2700;
  localparam logic [15:0] CAPS_HALF     = 16'h4ff6;
  localparam logic [7:0]  WRAP_OPCODE   = 8'hff;
  localparam logic [7:0]  WRAP_LENGTH   = 8'hff;
  localparam logic [15:0] LOCK_HALF     = 16'hcffe;
  localparam logic [7:0]  BLANK_BYTE    = 8'hff;
  localparam logic [31:0] BLANK_WORD    = 32'hffffffff;
  localparam logic [31:0] ZERO_WORD     = 32'h00000000;

  // ****************************************************************
  // Lane modes of the discovery read
  // ****************************************************************
  localparam logic [1:0] LANE_111 = 2'h0;
  localparam logic [1:0] LANE_222 = 2'h1;
  localparam logic [1:0] LANE_444 = 2'h2;

  // ****************************************************************
  // Control and status fields
  // ****************************************************************
  localparam int unsigned CTRL_LANE_LSB  = 0;
  localparam int unsigned CTRL_WAIT_LSB  = 4;
  localparam int unsigned CTRL_LATCH_SET = 8;
  localparam int unsigned CTRL_LATCH_CLR = 9;
  localparam int unsigned CTRL_SLEEP     = 10;
  localparam int unsigned CTRL_RELEASE   = 11;
  localparam int unsigned ST_READY       = 0;
  localparam int unsigned ST_LATCH       = 1;
  localparam int unsigned ST_SLEEP       = 2;
  localparam int unsigned ST_MODE_ERR    = 3;
  localparam int unsigned ST_LANE_LSB    = 4;
  localparam int unsigned ST_WAIT_LSB    = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] RST_LANE = 2'h0;
  localparam logic [3:0] RST_WAIT = 4'h0;

  typedef enum logic [1:0] {
    DVT_POR_WAIT = 2'b00,
    DVT_STANDBY  = 2'b01,
    DVT_SLEEP    = 2'b10
  } dvt_pwr_t;

endpackage

// file: verilog/dvt_table.sv
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Bytes 60h,61h read 00h,36h: 3.600 V max
// R2 - Bytes 62h,63h read 00h,27h: 2.700 V min
// R3 - Caps bits 0..3: no reset, pause, sleep
// R4 - Reset opcode FFh; halfword 64h reads 4FF6h
// R5 - Bits 12..15 read 0,0,1,0
// R6 - Byte 66h wrap opcode reads FFh
// R7 - Byte 67h wrap length reads FFh
// R8 - Lock word: no block lock, nonvolatile, FFh
// R9 - Unprotected default; lock low half CFFEh
// R10 - Secure area 1, locks 0, bits 15:14 11b
// R11 - Unused table bytes read FFh
// R12 - Only 1-1-1, 2-2-2, 4-4-4 lane modes
// R13 - Wait states delay data after address
// R14 - Host drives mode bits after address; the host model sends none
// R15 - Power-up: standby, write enable latch clear
// R16 - Host keeps device deselected during power-up
// R17 - No commands before select delay elapses
// R18 - Delivered array reads all FFh
// R19 - Word bytes least significant first
module dvt_table #(
  parameter int unsigned PWRUP_DELAY_CYC = dvt_pkg::PWRUP_DELAY_CYC,
  parameter int unsigned WAIT_W          = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             powerup_ready,
  output logic             write_enable_latch,
  output logic             deep_sleep
);

  // Counter wide enough to hold the whole power-up count
  localparam int unsigned CNT_W = $clog2(PWRUP_DELAY_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST =
    CNT_W'(PWRUP_DELAY_CYC - 1);

  // ****************************************************************
  // Register map
  // ****************************************************************
  // 00h control, write: [1:0] lane mode, [7:4] dummy cycles,
  //     [8] set latch, [9] clear latch, [10] sleep, [11] wake.
  //     Read gives back a subset of the status bits.
  // 04h status: [0] ready, [1] latch, [2] asleep, [3] mode error,
  //     [5:4] lane mode, [11:8] dummy cycles. Writing one to
  //     bit 3 clears the mode error.
  // 08h array window, read-only, always blank.
  // 60h supply word: maximum in bits 15:0, minimum in 31:16.
  // 64h capability halfword, then wrap opcode and wrap length.
  // 68h lock halfword, upper half unused.
  // 6Ch unused word.
  // Anything else is refused with an error and reads zero.
  //
  // Limitations worth knowing:
  // - The table is fixed at build time; nothing here can alter it.
  // - Dummy cycles stretch only table reads, as on the serial link
  //   they sit between address and data; other registers answer at
  //   once so status polling stays quick.
  // - A refused table read gets no dummy cycles, so the host learns
  //   of the refusal as early as possible.
  // - Clear beats set when both latch commands arrive together, so
  //   a confused write leaves the part safe.

  // ****************************************************************
  // State
  // ****************************************************************
  dvt_pkg::dvt_pwr_t   pwr_q, pwr_d;
  logic [CNT_W-1:0]    por_cnt_q, por_cnt_d;
  logic                latch_q, latch_d;
  logic [1:0]          lane_q, lane_d;
  logic [WAIT_W-1:0]   wait_q, wait_d;
  logic                mode_err_q, mode_err_d;
  logic [WAIT_W-1:0]   dly_q, dly_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                err_q, err_d;

  logic                setup;
  logic                done;
  logic                wr_done;
  logic                is_table;
  logic                ready;
  logic [31:0]         status_word;

  // Decode of the four table words
  function automatic logic in_table(input logic [7:0] a);
    return (a == dvt_pkg::OFS_SUPPLY) || (a == dvt_pkg::OFS_CAPS) ||
           (a == dvt_pkg::OFS_LOCK)   || (a == dvt_pkg::OFS_SPARE);
  endfunction

  // Lane codes the discovery read accepts
  function automatic logic lane_ok(input logic [1:0] m);
    return (m == dvt_pkg::LANE_111) || (m == dvt_pkg::LANE_222) ||
           (m == dvt_pkg::LANE_444); // [R12]
  endfunction

  // ****************************************************************
  // Bus phases
  // ****************************************************************
  assign setup    = psel && !penable;
  assign ready    = (pwr_q != dvt_pkg::DVT_POR_WAIT);
  assign is_table = in_table(paddr);
  // Access ends once the wait-state countdown has run out; pready
  // stays high while idle, so an access with no dummy cycles
  // completes in its first access cycle
  assign pready   = (dly_q == '0);
  assign done     = psel && penable && pready;
  assign wr_done  = done && pwrite && !err_q;
  assign pslverr  = psel && penable && pready && err_q;
  assign prdata   = rdata_q;

  // Status image; bits not listed read zero
  assign status_word = {
    {(32 - dvt_pkg::ST_WAIT_LSB - WAIT_W){1'b0}},
    wait_q,
    2'b00,
    lane_q,
    mode_err_q,
    (pwr_q == dvt_pkg::DVT_SLEEP),
    latch_q,
    ready
  };

  // ****************************************************************
  // Read data, error and wait states, all fixed at the setup cycle
  // ****************************************************************
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    dly_d   = dly_q;
    if (setup) begin
      rdata_d = dvt_pkg::ZERO_WORD;
      err_d   = 1'b0;
      dly_d   = '0;
      case (paddr)
        dvt_pkg::OFS_CTRL: begin
          // Readback hides the sleep and mode error bits
          rdata_d = status_word & 32'h00000ff3;
          // Commands before the select delay are refused
          err_d   = pwrite && !ready; // [R17]
        end
        dvt_pkg::OFS_STATUS: begin
          rdata_d = status_word;
        end
        dvt_pkg::OFS_ARRAY: begin
          rdata_d = dvt_pkg::BLANK_WORD; // [R18]
          err_d   = pwrite || !ready; // [R17]
        end
        dvt_pkg::OFS_SUPPLY: begin
          // Bits 7:0 hold byte 60h [R19]
          rdata_d = {dvt_pkg::SUPPLY_MIN, // [R2]
                     dvt_pkg::SUPPLY_MAX}; // [R1]
        end
        dvt_pkg::OFS_CAPS: begin
          rdata_d = {dvt_pkg::WRAP_LENGTH, // [R7]
                     dvt_pkg::WRAP_OPCODE, // [R6]
                     dvt_pkg::CAPS_HALF}; // [R3] [R4] [R5]
        end
        dvt_pkg::OFS_LOCK: begin
          rdata_d = {dvt_pkg::BLANK_BYTE, dvt_pkg::BLANK_BYTE, // [R11]
                     dvt_pkg::LOCK_HALF}; // [R8] [R9] [R10]
        end
        dvt_pkg::OFS_SPARE: begin
          rdata_d = dvt_pkg::BLANK_WORD; // [R11]
        end
        default: begin
          err_d = 1'b1;
        end
      endcase
      if (is_table) begin
        // Table is read-only; a sleeping part refuses table reads
        err_d = pwrite || !ready ||
                (pwr_q == dvt_pkg::DVT_SLEEP); // [R17]
        // Dummy cycles sit between address and first data
        if (!err_d) begin
          dly_d = wait_q; // [R13]
        end
      end
    end else if (psel && penable && (dly_q != '0)) begin
      dly_d = dly_q - 1'b1; // [R13]
    end
  end

  // ****************************************************************
  // Power state, latch and configuration
  // ****************************************************************
  // Power-up count, then standby; sleep and wake come from writes
  always_comb begin
    pwr_d      = pwr_q;
    por_cnt_d  = por_cnt_q;
    case (pwr_q)
      dvt_pkg::DVT_POR_WAIT: begin
        // Host keeps off the bus until this count ends
        if (por_cnt_q == CNT_LAST) begin
          pwr_d = dvt_pkg::DVT_STANDBY; // [R15] [R16]
        end else begin
          por_cnt_d = por_cnt_q + 1'b1;
        end
      end
      dvt_pkg::DVT_STANDBY: begin
        if (wr_done && (paddr == dvt_pkg::OFS_CTRL) &&
            pwdata[dvt_pkg::CTRL_SLEEP]) begin
          pwr_d = dvt_pkg::DVT_SLEEP;
        end
      end
      dvt_pkg::DVT_SLEEP: begin
        if (wr_done && (paddr == dvt_pkg::OFS_CTRL) &&
            pwdata[dvt_pkg::CTRL_RELEASE]) begin
          pwr_d = dvt_pkg::DVT_STANDBY;
        end
      end
      default: begin
        // Unused code falls back to the power-up wait
        pwr_d = dvt_pkg::DVT_POR_WAIT;
      end
    endcase
  end

  // Latch, lane mode, dummy cycles and mode error
  // Only a completed, unrefused write touches these, so a refused
  // access never leaves half a command behind
  always_comb begin
    latch_d    = latch_q;
    lane_d     = lane_q;
    wait_d     = wait_q;
    mode_err_d = mode_err_q;
    // Status write clears the error flag; a new error wins
    if (wr_done && (paddr == dvt_pkg::OFS_STATUS) &&
        pwdata[dvt_pkg::ST_MODE_ERR]) begin
      mode_err_d = 1'b0;
    end
    if (wr_done && (paddr == dvt_pkg::OFS_CTRL)) begin
      if (lane_ok(pwdata[dvt_pkg::CTRL_LANE_LSB +: 2])) begin
        lane_d = pwdata[dvt_pkg::CTRL_LANE_LSB +: 2];
      end else begin
        mode_err_d = 1'b1; // [R12]
      end
      wait_d = pwdata[dvt_pkg::CTRL_WAIT_LSB +: WAIT_W];
      // Latch commands are ignored while asleep
      if (pwr_q == dvt_pkg::DVT_STANDBY) begin
        if (pwdata[dvt_pkg::CTRL_LATCH_CLR]) begin
          latch_d = 1'b0;
        end else if (pwdata[dvt_pkg::CTRL_LATCH_SET]) begin
          latch_d = 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Bus group; idle with zero read data after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q   <= '0;
      rdata_q <= dvt_pkg::ZERO_WORD;
      err_q   <= 1'b0;
    end else begin
      dly_q   <= dly_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // Power group; power-up lands in standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q     <= dvt_pkg::DVT_POR_WAIT; // [R15]
      por_cnt_q <= '0;
    end else begin
      pwr_q     <= pwr_d;
      por_cnt_q <= por_cnt_d;
    end
  end

  // Configuration group; the latch starts cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q    <= 1'b0; // [R15]
      lane_q     <= dvt_pkg::RST_LANE;
      wait_q     <= dvt_pkg::RST_WAIT;
      mode_err_q <= 1'b0;
    end else begin
      latch_q    <= latch_d;
      lane_q     <= lane_d;
      wait_q     <= wait_d;
      mode_err_q <= mode_err_d;
    end
  end

  // Latch pin comes straight from its flop; ready and sleep pins are decoded from pwr_q
  assign powerup_ready      = ready;
  assign write_enable_latch = latch_q;
  assign deep_sleep         = (pwr_q == dvt_pkg::DVT_SLEEP);

endmodule

// file: test/dvt_table_chk.sv
`timescale 1ns/1ps
// ****
// Table checker
// ****
module dvt_table_chk #(
  parameter int unsigned PWRUP_DELAY_CYC = dvt_pkg::PWRUP_DELAY_CYC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        powerup_ready,
  input wire logic        write_enable_latch,
  input wire logic        deep_sleep
);
  logic [7:0] cyc_q;
  logic [7:0] cyc_d;
  // Edges since reset; saturates so a long run never wraps
  always_comb cyc_d = (cyc_q == 8'hff) ? cyc_q : cyc_q + 8'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc_q <= 8'h00;
    else cyc_q <= cyc_d;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(a);
    psel && penable && pready && !pslverr && !pwrite && paddr == a;
  endsequence
  property p_word(a, v);
    s_rd(a) |-> prdata == v;
  endproperty
  chk_supply_word: assert property (p_word(8'h60, 32'h27003600))
    else $error("supply word wrong");
  chk_caps_word: assert property (p_word(8'h64, 32'hffff4ff6))
    else $error("capability word wrong");
  chk_lock_word: assert property (p_word(8'h68, 32'hffffcffe))
    else $error("lock word wrong");
  chk_spare_word: assert property (p_word(8'h6c, 32'hffffffff))
    else $error("spare word wrong");
  chk_array_blank: assert property (p_word(8'h08, 32'hffffffff))
    else $error("array not blank");
  chk_powerup_delay: assert property ($rose(powerup_ready) |->
    cyc_q == PWRUP_DELAY_CYC)
    else $error("ready at wrong time");
  chk_powerup_state: assert property (!powerup_ready |->
    !write_enable_latch && !deep_sleep) else $error("bad power-up state");
  chk_table_ro: assert property (psel && penable && pready && pwrite
    && paddr >= 8'h60 |-> pslverr) else $error("table write taken");
endmodule

bind dvt_table dvt_table_chk #(.PWRUP_DELAY_CYC(PWRUP_DELAY_CYC)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .powerup_ready(powerup_ready),
  .write_enable_latch(write_enable_latch), .deep_sleep(deep_sleep));

// file: test/dvt_host.sv
`timescale 1ns/1ps
// ****
// Host controller model
// ****
module dvt_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  int n_wait;
  // Bus idles deselected from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // Held until pready; released address and write data show inverse so stale data is caught
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    // Access follows the address at once; no mode bits to send
    penable <= 1'b1;
    n_wait = -1;
    do begin
      @(posedge pclk);
      n_wait++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// file: test/dvt_table_test.sv
`timescale 1ns/1ps
// ****
// Testbench
// ****
module dvt_table_test;
  localparam int unsigned PDLY = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        powerup_ready, write_enable_latch, deep_sleep, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, total_checks, seed, n, m_lane, m_wait, m_latch, m_err;
  int          m_slp;
  logic [7:0]  adr_q[$] = '{8'h08, 8'h60, 8'h64, 8'h68, 8'h6c};
  dvt_table #(.PWRUP_DELAY_CYC(PDLY)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .powerup_ready(powerup_ready),
    .write_enable_latch(write_enable_latch), .deep_sleep(deep_sleep));
  dvt_host host_u (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected words, lowest byte address in bits 7:0
  function automatic logic [31:0] exp_word(input logic [7:0] a);
    case (a)
      8'h60: return {8'h27, 8'h00, 8'h36, 8'h00};
      8'h64: return {8'hff, 8'hff, 8'h4f, 8'hf6};
      8'h68: return {8'hff, 8'hff, 8'hcf, 8'hfe};
      default: return 32'hffffffff;
    endcase
  endfunction
  // Status against the model; reserved bits masked off
  task automatic stat;
    logic [31:0] st_exp;
    st_exp = 32'(m_wait << 8 | m_lane << 4 | m_err << 3 | m_slp << 2 |
                 m_latch << 1 | 1);
    host_u.xfer(1'b0, 8'h04, 32'h0, rd, er);
    chk("status", rd & 32'hf3f, st_exp);
    chk("latch_pin", {31'h0, write_enable_latch}, 32'(m_latch));
    chk("sleep_pin", {31'h0, deep_sleep}, 32'(m_slp));
  endtask
  // Control write, model updated from the old sleep state
  task automatic ctrl(input int ln, input int cmd);
    host_u.xfer(1'b1, 8'h00, 32'(cmd << 8 | m_wait << 4 | ln), rd, er);
    if (ln == 3) m_err = 1;
    else m_lane = ln;
    if (!m_slp && (cmd & 2)) m_latch = 0;
    else if (!m_slp && (cmd & 1)) m_latch = 1;
    if (!m_slp && (cmd & 4)) m_slp = 1;
    else if (m_slp && (cmd & 8)) m_slp = 0;
    stat;
  endtask
  // Main sequence
  initial begin
    {n_fail, total_checks, n, m_lane, m_wait, m_latch, m_err, m_slp} = '0;
    seed = 56728;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    while (powerup_ready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      // Look once the edge's updates have settled
      #1;
      n++;
    end
    chk("pwr_delay", n, PDLY);
    chk("sleep_pin", {31'h0, deep_sleep}, 32'h0);
    stat;
    foreach (adr_q[i]) begin
      host_u.xfer(1'b0, adr_q[i], 32'h0, rd, er);
      chk("table", rd, exp_word(adr_q[i]));
      chk("table_err", {31'h0, er}, 32'h0);
      host_u.xfer(1'b1, adr_q[i], $random(seed), rd, er);
      chk("ro_err", {31'h0, er}, 32'h1);
    end
    host_u.xfer(1'b0, 8'h20, 32'h0, rd, er);
    chk("unmapped", rd, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    for (int l = 0; l < 4; l++) begin
      m_wait = $random(seed) & 15;
      ctrl(l, 0);
      host_u.xfer(1'b0, 8'h64, 32'h0, rd, er);
      chk("wait", 32'(host_u.n_wait), 32'(m_wait));
      chk("caps", rd, exp_word(8'h64));
    end
    host_u.xfer(1'b1, 8'h04, 32'h8, rd, er);
    m_err = 0;
    stat;
    ctrl(m_lane, 1);
    ctrl(m_lane, 3);
    ctrl(m_lane, 5);
    host_u.xfer(1'b0, 8'h60, 32'h0, rd, er);
    chk("sleep_err", {31'h0, er}, 32'h1);
    ctrl(m_lane, 1);
    ctrl(m_lane, 8);
    finish_test;
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
endmodule
